// [rtl/mdv_defs.svh]
`ifndef MDV_DEFS_SVH
`define MDV_DEFS_SVH
// ****************************************************************
// Widths and pipeline shape
// ****************************************************************
`define MDV_PAIRS         4       // High/low accumulator pairs
`define MDV_MUL_STAGES    5       // Multiply pipe stages; commit one edge after the last
`define MDV_BOOTH_GROUPS  17      // Radix-4 groups for a 33-bit multiplier operand
`define MDV_DIV_BITS      6'h20   // Full divide iteration count
// ****************************************************************
// Early-in skip counts by dividend width
// ****************************************************************
`define MDV_SKIP_W8       6'h17
`define MDV_SKIP_W16      6'h0F
`define MDV_SKIP_W24      6'h07
`define MDV_SKIP_W32      6'h00
// ****************************************************************
// Divide latency in clocks, unsigned and signed
// ****************************************************************
`define MDV_LAT_U8        6'h0C
`define MDV_LAT_S8        6'h0E
`define MDV_LAT_U16       6'h14
`define MDV_LAT_S16       6'h16
`define MDV_LAT_U24       6'h1C
`define MDV_LAT_S24       6'h1E
`define MDV_LAT_U32       6'h24
`define MDV_LAT_S32       6'h26
`endif

// [rtl/mdv_divider.sv]
`timescale 1ns/1ps
`include "mdv_defs.svh"
// ****************************************************************
// Iterative restoring divider, one quotient bit per clock
// ****************************************************************
module mdv_divider (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        start_i,     // Start pulse, ignored while busy
  input  wire logic        signed_i,    // Signed operands
  input  wire logic [1:0]  pair_i,      // Destination pair
  input  wire logic [31:0] dividend_i,
  input  wire logic [31:0] divisor_i,
  output logic             busy_o,      // Divide in progress
  output logic             fin_o,       // Result written at the coming edge
  output logic [1:0]       pair_o,
  output logic [31:0]      quot_o,
  output logic [31:0]      rem_o
);
  mdv_pkg::mdv_div_state_t state, next_state;
  logic [5:0]  cnt, next_cnt;         // Clocks left until the result commits
  logic [5:0]  iters, next_iters;     // Quotient bits still to produce
  logic [31:0] quo, next_quo;         // Dividend shifting out, quotient shifting in
  logic [31:0] rem, next_rem;         // Partial remainder
  logic [31:0] dvs, next_dvs;         // Divisor magnitude
  logic        neg_q, next_neg_q;     // Quotient sign fix
  logic        neg_r, next_neg_r;     // Remainder takes the dividend sign
  logic        busy, next_busy;
  logic [1:0]  pair, next_pair;
  logic [31:0] a_mag, b_mag;
  logic [5:0]  skip, lat;
  logic [32:0] trial;
  logic        w8, w16, w24;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_iters = iters;
    next_quo   = quo;
    next_rem   = rem;
    next_dvs   = dvs;
    next_neg_q = neg_q;
    next_neg_r = neg_r;
    next_busy  = busy;
    next_pair  = pair;
    // Magnitudes; the sign is restored once all bits are out
    a_mag = (signed_i && dividend_i[31]) ? 32'(-dividend_i) : dividend_i;
    b_mag = (signed_i && divisor_i[31]) ? 32'(-divisor_i) : divisor_i;
    // Early-in: how far the sign extension of the dividend reaches
    if (signed_i) begin
      w8  = (&dividend_i[31:7]) | ~(|dividend_i[31:7]);
      w16 = (&dividend_i[31:15]) | ~(|dividend_i[31:15]);
      w24 = (&dividend_i[31:23]) | ~(|dividend_i[31:23]);
    end else begin
      w8  = ~(|dividend_i[31:8]);
      w16 = ~(|dividend_i[31:16]);
      w24 = ~(|dividend_i[31:24]);
    end
    // Skip count and total latency by width
    if (w8) begin
      skip = `MDV_SKIP_W8;
      lat  = signed_i ? `MDV_LAT_S8 : `MDV_LAT_U8;
    end else if (w16) begin
      skip = `MDV_SKIP_W16;
      lat  = signed_i ? `MDV_LAT_S16 : `MDV_LAT_U16;
    end else if (w24) begin
      skip = `MDV_SKIP_W24;
      lat  = signed_i ? `MDV_LAT_S24 : `MDV_LAT_U24;
    end else begin
      skip = `MDV_SKIP_W32;
      lat  = signed_i ? `MDV_LAT_S32 : `MDV_LAT_U32;
    end
    trial = {rem, quo[31]} - {1'b0, dvs};
    case (state)
      // Idle: load operands, pre-shifting past the skipped bits
      mdv_pkg::DIV_IDLE: begin
        if (start_i) begin
          next_quo   = a_mag << skip;
          next_rem   = '0;
          next_dvs   = b_mag;
          next_iters = `MDV_DIV_BITS - skip;
          next_cnt   = lat;
          next_neg_q = signed_i & (dividend_i[31] ^ divisor_i[31]);
          next_neg_r = signed_i & dividend_i[31];
          next_pair  = pair_i;
          next_busy  = 1'b1;
          next_state = mdv_pkg::DIV_ITER;
        end
      end
      // One restoring step per clock
      mdv_pkg::DIV_ITER: begin
        next_quo   = {quo[30:0], ~trial[32]};
        next_rem   = trial[32] ? {rem[30:0], quo[31]} : trial[31:0];
        next_iters = iters - 6'h01;
        next_cnt   = cnt - 6'h01;
        if (iters == 6'h01) begin
          next_state = mdv_pkg::DIV_SETTLE;
        end
      end
      // Sign fix-up and write-back slots until the latency runs out
      mdv_pkg::DIV_SETTLE: begin
        next_cnt = cnt - 6'h01;
        if (cnt == 6'h01) begin
          next_busy  = 1'b0;
          next_state = mdv_pkg::DIV_IDLE;
        end
      end
      default: begin
        next_busy  = 1'b0;
        next_state = mdv_pkg::DIV_IDLE;
      end
    endcase
  end

  // Result path; divide by zero leaves an all-ones style quotient, undefined
  assign fin_o  = (state == mdv_pkg::DIV_SETTLE) && (cnt == 6'h01);
  assign quot_o = neg_q ? 32'(-quo) : quo;
  assign rem_o  = neg_r ? 32'(-rem) : rem;
  assign busy_o = busy;
  assign pair_o = pair;

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state <= mdv_pkg::DIV_IDLE;
      cnt   <= '0;
      iters <= '0;
      quo   <= '0;
      rem   <= '0;
      dvs   <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      busy  <= 1'b0;
      pair  <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      iters <= next_iters;
      quo   <= next_quo;
      rem   <= next_rem;
      dvs   <= next_dvs;
      neg_q <= next_neg_q;
      neg_r <= next_neg_r;
      busy  <= next_busy;
      pair  <= next_pair;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  bit_per_clock_a: assert property ((state == mdv_pkg::DIV_ITER && iters != 6'h01) |=>
    (iters == $past(iters) - 6'h01)) else $error("divide did not retire one bit");
  skip_w16_a: assert property ((start_i && !busy && !w8 && w16) |=>
    (iters == 6'h11)) else $error("16-bit dividend skip count wrong");
  lat_u8_a: assert property ((start_i && !busy && !signed_i && w8) |->
    ##12 fin_o) else $error("unsigned 8-bit divide latency wrong");
  lat_s32_a: assert property ((start_i && !busy && signed_i && !w24) |->
    !fin_o [*8] ##31 fin_o) else $error("signed 32-bit divide latency wrong");
  // A divide may be taken again on the edge right after busy drops
  busy_drop_a: assert property (fin_o |=> !busy_o ##1 (busy_o == $past(start_i)))
    else $error("busy held after divide result");
  cover_div_s8_c: cover property (start_i && !busy && signed_i && w8 ##14 fin_o);
endmodule : mdv_divider

// [rtl/mdv_pkg.sv]
// ****************************************************************
// Shared types
// ****************************************************************
package mdv_pkg;
  // Operations issued by the integer pipeline
  typedef enum logic [3:0] {
    OP_SIGNED_MULTIPLY_TO_ACC,
    OP_UNSIGNED_MULTIPLY_TO_ACC,
    OP_SIGNED_MULTIPLY_ADD,
    OP_UNSIGNED_MULTIPLY_ADD,
    OP_SIGNED_MULTIPLY_SUBTRACT,
    OP_UNSIGNED_MULTIPLY_SUBTRACT,
    OP_MULTIPLY_TO_GPR,
    OP_SPX_DUAL_MULTIPLY_ADD,
    OP_READ_HIGH_ACC,
    OP_READ_LOW_ACC,
    OP_SIGNED_DIVIDE,
    OP_UNSIGNED_DIVIDE
  } mdv_op_t;
  // Divide sequencer states
  typedef enum logic [1:0] {
    DIV_IDLE,
    DIV_ITER,
    DIV_SETTLE
  } mdv_div_state_t;
endpackage : mdv_pkg

// [rtl/mdv_unit.sv]
`timescale 1ns/1ps
`include "mdv_defs.svh"
module mdv_unit (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             issue_valid_i,              // Operation offered
  input  mdv_pkg::mdv_op_t      issue_op_i,
  input  wire logic [1:0]       issue_pair_i,               // Accumulator pair
  input  wire logic [31:0]      first_source_operand_i,
  input  wire logic [31:0]      second_source_operand_i,
  output logic [31:0]           result_o,                   // General register result
  output logic                  result_valid_o,             // One-clock pulse
  output logic                  div_busy_o                  // Stall request to the issuer
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic                 st_valid [`MDV_MUL_STAGES];        // Pipe stage occupied
  mdv_pkg::mdv_op_t     st_op    [`MDV_MUL_STAGES];
  logic [1:0]           st_pair  [`MDV_MUL_STAGES];
  logic [63:0]          st_val   [`MDV_MUL_STAGES];        // Operands, then product
  logic                 next_st_valid [`MDV_MUL_STAGES];
  mdv_pkg::mdv_op_t     next_st_op    [`MDV_MUL_STAGES];
  logic [1:0]           next_st_pair  [`MDV_MUL_STAGES];
  logic [63:0]          next_st_val   [`MDV_MUL_STAGES];
  logic [31:0]          high_acc [`MDV_PAIRS];             // Upper result words
  logic [31:0]          low_acc  [`MDV_PAIRS];             // Lower result words
  logic [31:0]          next_high_acc [`MDV_PAIRS];
  logic [31:0]          next_low_acc  [`MDV_PAIRS];
  logic [31:0]          result, next_result;
  logic                 result_valid, next_result_valid;
  logic                 accept, is_div, div_start;
  logic                 div_busy, div_fin;
  logic [1:0]           div_pair;
  logic [31:0]          div_quot, div_rem;
  logic [63:0]          cur, last;
  logic [1:0]           lp;

  // Radix-4 Booth product of two 33-bit signed operands
  function automatic logic [63:0] booth_product(input logic [32:0] a, input logic [32:0] b);
    logic [65:0] sum;
    logic [65:0] ax;
    logic [65:0] pp;
    logic [35:0] bx;
    sum = '0;
    ax  = {{33{a[32]}}, a};
    bx  = {{2{b[32]}}, b, 1'b0};
    pp  = '0;
    for (int i = 0; i < `MDV_BOOTH_GROUPS; i++) begin
      case (bx[2*i +: 3])
        3'h1, 3'h2: pp = ax;
        3'h3:       pp = ax << 1;
        3'h4:       pp = 66'(-(ax << 1));
        3'h5, 3'h6: pp = 66'(-ax);
        default:    pp = '0;
      endcase
      sum = 66'(sum + (pp << (2*i)));
    end
    return sum[63:0];
  endfunction : booth_product

  // ****************************************************************
  // Issue and divider
  // ****************************************************************
  // A busy divider refuses everything; the issuer holds its request
  always_comb begin
    is_div    = (issue_op_i == mdv_pkg::OP_SIGNED_DIVIDE) ||
                (issue_op_i == mdv_pkg::OP_UNSIGNED_DIVIDE);
    accept    = issue_valid_i && !div_busy;
    div_start = accept && is_div;
  end

  mdv_divider u_divider (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .start_i    (div_start),
    .signed_i   (issue_op_i == mdv_pkg::OP_SIGNED_DIVIDE),
    .pair_i     (issue_pair_i),
    .dividend_i (first_source_operand_i),
    .divisor_i  (second_source_operand_i),
    .busy_o     (div_busy),
    .fin_o      (div_fin),
    .pair_o     (div_pair),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  // ****************************************************************
  // Multiply pipeline and accumulators
  // ****************************************************************
  // No stall input exists: stages advance every clock
  always_comb begin
    next_st_valid[0] = accept && !is_div;
    next_st_op[0]    = issue_op_i;
    next_st_pair[0]  = issue_pair_i;
    next_st_val[0]   = {first_source_operand_i, second_source_operand_i};
    for (int s = 1; s < `MDV_MUL_STAGES; s++) begin
      next_st_valid[s] = st_valid[s-1];
      next_st_op[s]    = st_op[s-1];
      next_st_pair[s]  = st_pair[s-1];
      next_st_val[s]   = st_val[s-1];
    end
    // Product formed between stages one and two
    case (st_op[0])
      mdv_pkg::OP_UNSIGNED_MULTIPLY_TO_ACC, mdv_pkg::OP_UNSIGNED_MULTIPLY_ADD,
      mdv_pkg::OP_UNSIGNED_MULTIPLY_SUBTRACT:
        next_st_val[1] = booth_product({1'b0, st_val[0][63:32]}, {1'b0, st_val[0][31:0]});
      mdv_pkg::OP_SPX_DUAL_MULTIPLY_ADD:
        next_st_val[1] = 64'(booth_product({{17{st_val[0][47]}}, st_val[0][47:32]},
                                           {{17{st_val[0][15]}}, st_val[0][15:0]}) +
                             booth_product({{17{st_val[0][63]}}, st_val[0][63:48]},
                                           {{17{st_val[0][31]}}, st_val[0][31:16]}));
      mdv_pkg::OP_READ_HIGH_ACC, mdv_pkg::OP_READ_LOW_ACC:
        next_st_val[1] = st_val[0];
      default:
        next_st_val[1] = booth_product({st_val[0][63], st_val[0][63:32]},
                                       {st_val[0][31], st_val[0][31:0]});
    endcase
    for (int p = 0; p < `MDV_PAIRS; p++) begin
      next_high_acc[p] = high_acc[p];
      next_low_acc[p]  = low_acc[p];
    end
    // Commit from the last stage: five clocks after issue
    lp                = st_pair[`MDV_MUL_STAGES-1];
    last              = st_val[`MDV_MUL_STAGES-1];
    cur               = {high_acc[lp], low_acc[lp]};
    next_result       = result;
    next_result_valid = 1'b0;
    if (st_valid[`MDV_MUL_STAGES-1]) begin
      case (st_op[`MDV_MUL_STAGES-1])
        mdv_pkg::OP_SIGNED_MULTIPLY_ADD, mdv_pkg::OP_UNSIGNED_MULTIPLY_ADD,
        mdv_pkg::OP_SPX_DUAL_MULTIPLY_ADD:
          {next_high_acc[lp], next_low_acc[lp]} = 64'(cur + last);
        mdv_pkg::OP_SIGNED_MULTIPLY_SUBTRACT, mdv_pkg::OP_UNSIGNED_MULTIPLY_SUBTRACT:
          {next_high_acc[lp], next_low_acc[lp]} = 64'(cur - last);
        mdv_pkg::OP_MULTIPLY_TO_GPR: begin
          next_result       = last[31:0];
          next_result_valid = 1'b1;
        end
        mdv_pkg::OP_READ_HIGH_ACC: begin
          next_result       = high_acc[lp];
          next_result_valid = 1'b1;
        end
        mdv_pkg::OP_READ_LOW_ACC: begin
          next_result       = low_acc[lp];
          next_result_valid = 1'b1;
        end
        default:
          {next_high_acc[lp], next_low_acc[lp]} = last;
      endcase
    end
    // Divide result: remainder high, quotient low
    if (div_fin) begin
      next_high_acc[div_pair] = div_rem;
      next_low_acc[div_pair]  = div_quot;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      for (int s = 0; s < `MDV_MUL_STAGES; s++) begin
        st_valid[s] <= 1'b0;
        st_op[s]    <= mdv_pkg::OP_SIGNED_MULTIPLY_TO_ACC;
        st_pair[s]  <= '0;
        st_val[s]   <= '0;
      end
      for (int p = 0; p < `MDV_PAIRS; p++) begin
        high_acc[p] <= '0;
        low_acc[p]  <= '0;
      end
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      for (int s = 0; s < `MDV_MUL_STAGES; s++) begin
        st_valid[s] <= next_st_valid[s];
        st_op[s]    <= next_st_op[s];
        st_pair[s]  <= next_st_pair[s];
        st_val[s]   <= next_st_val[s];
      end
      for (int p = 0; p < `MDV_PAIRS; p++) begin
        high_acc[p] <= next_high_acc[p];
        low_acc[p]  <= next_low_acc[p];
      end
      result       <= next_result;
      result_valid <= next_result_valid;
    end
  end

  assign result_o       = result;
  assign result_valid_o = result_valid;
  assign div_busy_o     = div_busy;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [63:0] ref_prod;         // Reference signed product
  logic        gpr_acc;          // Accepted multiply to general register
  // Operands widened first so the product is formed at full width
  assign ref_prod = {{32{first_source_operand_i[31]}}, first_source_operand_i} *
                    {{32{second_source_operand_i[31]}}, second_source_operand_i};
  assign gpr_acc  = accept && issue_op_i == mdv_pkg::OP_MULTIPLY_TO_GPR;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Earlier back-to-back results may pulse in between, so only the slot is checked
  mul_latency_a: assert property (gpr_acc |-> ##6 (result_valid_o &&
    result_o == $past(ref_prod[31:0], 6))) else $error("multiply result not after five clocks");
  back_to_back_a: assert property ((gpr_acc ##1 gpr_acc) |->
    ##6 (result_valid_o && $past(result_valid_o))) else $error("back-to-back multiply lost");
  booth_acc_a: assert property ((accept && issue_pair_i == 2'h0 &&
    issue_op_i == mdv_pkg::OP_SIGNED_MULTIPLY_TO_ACC) |-> ##6
    ({high_acc[0], low_acc[0]} == $past(ref_prod, 6))) else $error("pair 0 product wrong");
  stall_refuse_a: assert property ((issue_valid_i && div_busy_o) |=> !st_valid[0])
    else $error("operation taken while dividing");
  pipe_advance_a: assert property (st_valid[0] |-> ##4 st_valid[`MDV_MUL_STAGES-1])
    else $error("multiply pipeline stalled");
  div_write_a: assert property (div_fin |=> (low_acc[$past(div_pair)] == $past(div_quot)) &&
    !div_busy_o) else $error("divide result not written as busy drops");
  cover_b2b_c: cover property (gpr_acc ##1 gpr_acc ##1 gpr_acc);
  cover_div_c: cover property (div_start ##[12:38] div_fin);
  cover_spx_c: cover property (accept && issue_op_i == mdv_pkg::OP_SPX_DUAL_MULTIPLY_ADD);
  cover_refuse_c: cover property (issue_valid_i && div_busy_o);
endmodule : mdv_unit

// [verification/mdv_issuer_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Integer pipeline side: offers operations to the unit
// ****************************************************************
module mdv_issuer_model (
  input  wire logic         ref_clk_i,
  input  wire logic         div_busy_i,     // Stall request from the unit
  output logic              issue_valid_o,  // Operation offered
  output mdv_pkg::mdv_op_t  issue_op_o,
  output logic [1:0]        issue_pair_o,
  output logic [31:0]       first_o,        // Multiplicand or dividend
  output logic [31:0]       second_o        // Multiplier or divisor
);
  // Quiet at time zero
  initial begin
    issue_valid_o = 1'b0;
    issue_op_o    = mdv_pkg::OP_READ_LOW_ACC;
    issue_pair_o  = 2'h0;
    first_o       = 32'h0;
    second_o      = 32'h0;
  end
  // Offer one operation at a rising edge; return at the edge that takes it
  task automatic offer(input mdv_pkg::mdv_op_t op, input logic [1:0] pair,
                       input logic [31:0] a, input logic [31:0] b);
    issue_valid_o <= 1'b1;
    issue_op_o    <= op;
    issue_pair_o  <= pair;
    first_o       <= a;
    second_o      <= b;
    // Held unchanged while busy: a refused issue is never queued by the unit
    do @(posedge ref_clk_i); while (div_busy_i !== 1'b0);
  endtask : offer
  // Release; operands flipped so no one leans on stale values
  task automatic idle();
    issue_valid_o <= 1'b0;
    first_o       <= ~first_o;
    second_o      <= ~second_o;
  endtask : idle
endmodule : mdv_issuer_model

// [verification/mdv_unit_tb.sv]
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the multiply/divide unit
// ****************************************************************
module mdv_unit_tb;
  logic              ref_clk_i = 1'b0;
  logic              nrst_i;
  logic              issue_valid_i;
  mdv_pkg::mdv_op_t  issue_op_i;
  logic [1:0]        issue_pair_i;
  logic [31:0]       first_i;
  logic [31:0]       second_i;
  logic [31:0]       result_o;
  logic              result_valid_o;
  logic              div_busy_o;
  integer            seed = 5309;        // Fixed seed, repeatable runs
  int                miscompares = 0;
  int                checked = 0;
  int                cyc = 0;            // Edge index seen by every process
  logic [63:0]       acc [4] = '{default: 64'h0}; // Reference accumulator pairs
  logic [31:0]       exp_val [$];        // Expected general results, in order
  int                exp_cyc [$];        // Edge at which each pulse is sampled
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  mdv_unit i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .issue_valid_i(issue_valid_i),
    .issue_op_i(issue_op_i), .issue_pair_i(issue_pair_i), .first_source_operand_i(first_i),
    .second_source_operand_i(second_i), .result_o(result_o),
    .result_valid_o(result_valid_o), .div_busy_o(div_busy_o));
  mdv_issuer_model i_issuer (.ref_clk_i(ref_clk_i), .div_busy_i(div_busy_o),
    .issue_valid_o(issue_valid_i), .issue_op_o(issue_op_i), .issue_pair_o(issue_pair_i),
    .first_o(first_i), .second_o(second_i));
  // ****************************************************************
  // Comparison, verdict and watchdog
  // ****************************************************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // Run should end near 930 clocks; about eleven times that means a hang
  initial begin
    #(25 * 10000);
    miscompares++;
    close_out();
  end
  // Every result pulse must match the oldest expectation, value and edge
  always @(posedge ref_clk_i) begin
    if (nrst_i === 1'b1 && result_valid_o !== 1'b0) begin
      if (exp_val.size() == 0) begin
        check("spurious result", 64'h1, 64'h0);
      end else begin
        check("result value", 64'(result_o), 64'(exp_val.pop_front()));
        check("result edge", 64'(exp_cyc.pop_front()), 64'(cyc));
      end
    end
  end
  // ****************************************************************
  // Reference model of the pipeline, applied at the take edge
  // ****************************************************************
  task automatic run_op(input mdv_pkg::mdv_op_t op, input logic [1:0] pair,
                        input logic [31:0] a, input logic [31:0] b);
    logic [63:0] sp;
    logic [63:0] up;
    logic [63:0] dual;
    i_issuer.offer(op, pair, a, b);
    sp   = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    up   = {32'h0, a} * {32'h0, b};
    dual = {{48{a[15]}}, a[15:0]} * {{48{b[15]}}, b[15:0]}
         + {{48{a[31]}}, a[31:16]} * {{48{b[31]}}, b[31:16]};
    // General results show on the sixth edge after the take
    if (op == mdv_pkg::OP_MULTIPLY_TO_GPR || op == mdv_pkg::OP_READ_HIGH_ACC
        || op == mdv_pkg::OP_READ_LOW_ACC) begin
      exp_cyc.push_back(cyc + 6);
    end
    case (op)
      mdv_pkg::OP_SIGNED_MULTIPLY_TO_ACC:     acc[pair] = sp;
      mdv_pkg::OP_UNSIGNED_MULTIPLY_TO_ACC:   acc[pair] = up;
      mdv_pkg::OP_SIGNED_MULTIPLY_ADD:        acc[pair] = acc[pair] + sp;
      mdv_pkg::OP_UNSIGNED_MULTIPLY_ADD:      acc[pair] = acc[pair] + up;
      mdv_pkg::OP_SIGNED_MULTIPLY_SUBTRACT:   acc[pair] = acc[pair] - sp;
      mdv_pkg::OP_UNSIGNED_MULTIPLY_SUBTRACT: acc[pair] = acc[pair] - up;
      mdv_pkg::OP_SPX_DUAL_MULTIPLY_ADD:      acc[pair] = acc[pair] + dual;
      mdv_pkg::OP_MULTIPLY_TO_GPR:            exp_val.push_back(sp[31:0]);
      mdv_pkg::OP_READ_HIGH_ACC:              exp_val.push_back(acc[pair][63:32]);
      mdv_pkg::OP_READ_LOW_ACC:               exp_val.push_back(acc[pair][31:0]);
      default: ;                              // Divides handled by run_div
    endcase
  endtask : run_op
  // Divide latency from the dividend's sign extension
  function automatic int div_lat(input logic sgn, input logic [31:0] d);
    int w;
    if (sgn) begin
      w = (d[31:7] == {25{d[31]}}) ? 0 : (d[31:15] == {17{d[31]}}) ? 1
        : (d[31:23] == {9{d[31]}}) ? 2 : 3;
    end else begin
      w = (d[31:8] == 24'h0) ? 0 : (d[31:16] == 16'h0) ? 1 : (d[31:24] == 8'h0) ? 2 : 3;
    end
    return 12 + 8 * w + (sgn ? 2 : 0);
  endfunction : div_lat
  // Divide, then a read offered at once must stall until the divide is done
  task automatic run_div(input logic sgn, input logic [1:0] pair,
                         input logic [31:0] a, input logic [31:0] b);
    int t0;
    i_issuer.offer(sgn ? mdv_pkg::OP_SIGNED_DIVIDE : mdv_pkg::OP_UNSIGNED_DIVIDE, pair, a, b);
    t0 = cyc;
    acc[pair] = sgn ? {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))}
                    : {a % b, a / b};
    run_op(mdv_pkg::OP_READ_LOW_ACC, pair, a, b);
    check("divide stall", 64'(cyc - t0), 64'(div_lat(sgn, a) + 1));
    run_op(mdv_pkg::OP_READ_HIGH_ACC, pair, a, b);
  endtask : run_div
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] corner [6];
    corner = '{32'h0000_007F, 32'h0000_0080, 32'hFFFF_FF80, 32'h0000_00FF,
               32'h0000_0100, 32'h8000_0000};
    nrst_i = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    check("reset busy", 64'(div_busy_o), 64'h0);
    check("reset result", 64'(result_o), 64'h0);
    for (int p = 0; p < 4; p++) begin
      run_op(mdv_pkg::OP_READ_HIGH_ACC, 2'(p), 32'h0, 32'h0);
      run_op(mdv_pkg::OP_READ_LOW_ACC, 2'(p), 32'h0, 32'h0);
    end
    $display("test reset state done, miscompares %0d", miscompares);
    // Back-to-back random multiplies and accumulator reads, some with 16-bit multipliers
    for (int i = 0; i < 300; i++) begin
      a = $random(seed);
      b = $random(seed);
      if (i % 3 == 0) b = b & 32'h0000_FFFF;
      run_op(mdv_pkg::mdv_op_t'(4'($unsigned($random(seed)) % 10)), 2'($random(seed)), a, b);
    end
    $display("test back-to-back multiplies done, miscompares %0d", miscompares);
    // Every dividend width, signed and unsigned, plus boundary dividends
    for (int i = 0; i < 20; i++) begin
      a = $random(seed);
      b = $random(seed);
      b = (i % 2 == 0) ? {28'h0, b[3:2], 2'h2} : {b[31:1], 1'b0} | 32'h2;
      a = (i < 8) ? (i[0] ? 32'($signed(a) >>> (24 - 8 * (i / 2))) : a >> (24 - 8 * (i / 2)))
        : (i < 14) ? corner[i - 8] : a;
      run_div(i[0] ^ (i >= 8 && i < 14), 2'(i), a, b);
    end
    $display("test divides done, miscompares %0d", miscompares);
    i_issuer.idle();
    repeat (8) @(posedge ref_clk_i);
    check("pending results", 64'(exp_val.size()), 64'h0);
    close_out();
  end
endmodule : mdv_unit_tb
